// ### rtl/lioenc_top.sv
// Purpose: Digital I/O lines and rotary encoder unit of a line camera
// Assumes: One 100 MHz clock; settings and camera levels are synchronous
// Notes: Only line pins are asynchronous and pass two flip-flops
//
// Notes on behaviour
// - Three inputs, two outputs, selector targets settings
// - Inverter setting flips selected input, default off
// - Output line driven from its chosen source
// - Four-phase mode: filtered, one count per cycle
// - High resolution: each transition counts, no filter
// - Divider 1 to 200 thins encoder pulses
// - Encoder output mode shows position, direction, motion
// - Selected reset source clears the position counter
// - Reset source qualified by edge or level
// - Position count readable, writable, 0 to 999999
// - Count captured into position_at_clear on reset
// - Software reset clears counter regardless of source
`include "lioenc_defines.svh"
module lioenc_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [2:0] i_line_pin,
  input wire logic i_line_wr,
  input wire lioenc_pkg::lioenc_line_cfg_t i_line_cfg,
  input wire lioenc_pkg::lioenc_enc_cfg_t i_enc_cfg,
  input wire lioenc_pkg::lioenc_cam_t i_cam,
  input wire logic i_enc_reset,
  input wire logic i_pos_wr,
  input wire logic [19:0] i_pos_wdata,
  output logic [1:0] o_line_out,
  output logic o_line_status,
  output logic o_line_direction,
  output logic [19:0] o_position,
  output logic [31:0] o_position_at_clear,
  output logic o_direction
);

  localparam int CycPerUs = `LIOENC_CYC_PER_US;

  ////////////////////////////////////////////////////////////////////////
  // Pick an input line by a one-based select, zero means off
  function automatic logic pick_line(input logic [1:0] sel,
                                     input logic [2:0] lines);
    pick_line = (sel == 2'h0) ? 1'b0 : lines[sel - 2'h1];
  endfunction

  // Quadrature step: bit 1 forward, bit 0 reverse, order A leads B
  function automatic logic [1:0] quad_dir(input logic [1:0] prev,
                                          input logic [1:0] cur);
    logic [1:0] nxt; // Forward successor of prev
    logic [1:0] bck; // Reverse successor of prev
    nxt = 2'h0;
    bck = 2'h0;
    case (prev)
      2'h0: nxt = 2'h2;
      2'h2: nxt = 2'h3;
      2'h3: nxt = 2'h1;
      default: nxt = 2'h0;
    endcase
    // Reverse order AB 00,01,11,10
    case (prev)
      2'h0: bck = 2'h1;
      2'h1: bck = 2'h3;
      2'h3: bck = 2'h2;
      default: bck = 2'h0;
    endcase
    quad_dir = {cur == nxt, cur == bck};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, first stage read only by the second
  logic [2:0] sync1_q, sync2_q;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= i_line_pin;
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-line settings, written for the selected line
  logic [2:0] inv_q, inv_d; // Input inverters
  logic [16:0] rise_q [3], rise_d [3]; // Rise mask times, us
  logic [16:0] fall_q [3], fall_d [3]; // Fall mask times, us
  lioenc_pkg::lioenc_osrc_t src_q [2], src_d [2]; // Output sources
  logic [6:0] tick_q, tick_d; // Microsecond prescaler

  always_comb
  begin
    inv_d = inv_q;
    rise_d = rise_q;
    fall_d = fall_q;
    src_d = src_q;
    tick_d = (tick_q == 7'(CycPerUs - 1)) ? 7'h00 : tick_q + 7'h01;
    if (i_line_wr)
    begin
      if (i_line_cfg.sel <= lioenc_pkg::LIOENC_LIN3)
      begin
        // Input line: inverter and mask times apply
        inv_d[i_line_cfg.sel[1:0]] = i_line_cfg.inverter;
        rise_d[i_line_cfg.sel[1:0]] = i_line_cfg.rise_mask_time;
        fall_d[i_line_cfg.sel[1:0]] = i_line_cfg.fall_mask_time;
      end
      else if (i_line_cfg.sel == lioenc_pkg::LIOENC_LOUT1)
        src_d[0] = i_line_cfg.source;
      else if (i_line_cfg.sel == lioenc_pkg::LIOENC_LOUT2)
        src_d[1] = i_line_cfg.source;
    end
  end

  // Settings registers, all false or off after reset
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      inv_q <= 3'h0;
      rise_q <= '{default: 17'h00000};
      fall_q <= '{default: 17'h00000};
      src_q <= '{default: lioenc_pkg::LIOENC_OSRC_OFF};
      tick_q <= 7'h00;
    end
    else
    begin
      inv_q <= inv_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      src_q <= src_d;
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Inverter then edge mask on each input line
  logic [2:0] line_proc; // Processed input levels
  for (genvar g = 0; g < 3; g++)
  begin : g_in
    lioenc_mask u_mask (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_level(sync2_q[g] ^ inv_q[g]),
      .i_tick(tick_q == 7'h00),
      .i_rise_mask_time(rise_q[g]),
      .i_fall_mask_time(fall_q[g]),
      .o_level(line_proc[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Encoder phase filter and decode
  logic [1:0] ab_raw, ab_use, cand_q, cand_d, filt_q, filt_d, prev_q;
  logic [1:0] fcnt_q, fcnt_d, qd;
  logic hires, step_fwd, step_rev;

  always_comb
  begin
    ab_raw = {pick_line(i_enc_cfg.src_a, line_proc),
              pick_line(i_enc_cfg.src_b, line_proc)};
    hires = i_enc_cfg.mode == lioenc_pkg::LIOENC_EMODE_HIRES;
    cand_d = cand_q;
    filt_d = filt_q;
    fcnt_d = fcnt_q;
    // Pair must stand several cycles before it counts
    if (ab_raw != cand_q)
    begin
      cand_d = ab_raw;
      fcnt_d = 2'h0;
    end
    else if (fcnt_q == `LIOENC_FILT_CYC)
      filt_d = cand_q;
    else
      fcnt_d = fcnt_q + 2'h1;
    ab_use = hires ? ab_raw : filt_q;
    qd = quad_dir(prev_q, ab_use);
    if (hires)
    begin
      // Every transition counts
      step_fwd = qd[1];
      step_rev = qd[0];
    end
    else
    begin
      // One count per full four-state cycle
      step_fwd = qd[1] && prev_q == 2'h0;
      step_rev = qd[0] && prev_q == 2'h2 && ab_use == 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset source level and activation
  logic [8:0] rsrc_lvl;
  logic rst_lvl, rst_prev_q, rst_hit, rst_any;
  always_comb
  begin
    rsrc_lvl = {line_proc[2], line_proc[1], line_proc[0],
                ~i_cam.exposure_active, i_cam.exposure_active,
                ~i_cam.frame_active, i_cam.frame_active,
                ~i_cam.acq_active, 1'b0};
    rst_lvl = (i_enc_cfg.rst_src > lioenc_pkg::LIOENC_RSRC_IN3) ? 1'b0
              : rsrc_lvl[i_enc_cfg.rst_src];
    case (i_enc_cfg.rst_act)
      lioenc_pkg::LIOENC_RACT_RISE: rst_hit = rst_lvl & ~rst_prev_q;
      lioenc_pkg::LIOENC_RACT_FALL: rst_hit = ~rst_lvl & rst_prev_q;
      lioenc_pkg::LIOENC_RACT_ANY: rst_hit = rst_lvl ^ rst_prev_q;
      lioenc_pkg::LIOENC_RACT_HIGH: rst_hit = rst_lvl;
      lioenc_pkg::LIOENC_RACT_LOW: rst_hit = ~rst_lvl;
      default: rst_hit = 1'b0;
    endcase
    if (i_enc_cfg.rst_src == lioenc_pkg::LIOENC_RSRC_OFF)
      rst_hit = 1'b0;
    rst_any = rst_hit | i_enc_reset;
  end

  ////////////////////////////////////////////////////////////////////////
  // Position, capture, divider and encoder output
  logic [19:0] pos_q, pos_d;
  logic [31:0] clr_q, clr_d;
  logic [7:0] div_cnt_q, div_cnt_d, eff_div;
  logic dir_q, dir_d, divp_q, divp_d, divfwd_q, divfwd_d, eout_q, eout_d;

  always_comb
  begin
    pos_d = pos_q;
    clr_d = clr_q;
    dir_d = dir_q;
    div_cnt_d = div_cnt_q;
    divp_d = 1'b0;
    divfwd_d = divfwd_q;
    eff_div = (i_enc_cfg.divider < `LIOENC_DIV_MIN) ? `LIOENC_DIV_MIN
            : (i_enc_cfg.divider > `LIOENC_DIV_MAX) ? `LIOENC_DIV_MAX
            : i_enc_cfg.divider;
    if (rst_any)
    begin
      // Reset wins over a write and a count
      pos_d = 20'h00000;
      clr_d = {12'h000, pos_q};
    end
    else if (i_pos_wr)
      pos_d = (i_pos_wdata > `LIOENC_POS_MAX) ? `LIOENC_POS_MAX
            : i_pos_wdata;
    else if (step_fwd)
      pos_d = (pos_q == `LIOENC_POS_MAX) ? 20'h00000
            : pos_q + 20'h00001;
    else if (step_rev)
      pos_d = (pos_q == 20'h00000) ? `LIOENC_POS_MAX
            : pos_q - 20'h00001;
    if (step_fwd | step_rev)
    begin
      dir_d = step_fwd;
      // One output pulse per divider count of steps
      if (div_cnt_q + 8'h01 >= eff_div)
      begin
        div_cnt_d = 8'h00;
        divp_d = 1'b1;
        divfwd_d = step_fwd;
      end
      else
        div_cnt_d = div_cnt_q + 8'h01;
    end
    case (i_enc_cfg.out_mode)
      lioenc_pkg::LIOENC_EOUT_POS_UP: eout_d = divp_q & divfwd_q;
      lioenc_pkg::LIOENC_EOUT_POS_DN: eout_d = divp_q & ~divfwd_q;
      lioenc_pkg::LIOENC_EOUT_DIR_UP: eout_d = dir_q;
      lioenc_pkg::LIOENC_EOUT_DIR_DN: eout_d = ~dir_q;
      lioenc_pkg::LIOENC_EOUT_MOTION: eout_d = divp_q;
      default: eout_d = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output line and selected-line status next values
  logic [1:0] out_q, out_d;
  logic stat_q, stat_d, ldir_q, ldir_d;
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      case (src_q[i])
        lioenc_pkg::LIOENC_OSRC_ACQ: out_d[i] = i_cam.acq_active;
        lioenc_pkg::LIOENC_OSRC_FRAME: out_d[i] = i_cam.frame_active;
        lioenc_pkg::LIOENC_OSRC_EXPO: out_d[i] = i_cam.exposure_active;
        lioenc_pkg::LIOENC_OSRC_ENC: out_d[i] = eout_q;
        lioenc_pkg::LIOENC_OSRC_IN1: out_d[i] = line_proc[0];
        lioenc_pkg::LIOENC_OSRC_IN2: out_d[i] = line_proc[1];
        lioenc_pkg::LIOENC_OSRC_IN3: out_d[i] = line_proc[2];
        default: out_d[i] = 1'b0;
      endcase
    end
    ldir_d = i_line_cfg.sel >= lioenc_pkg::LIOENC_LOUT1;
    case (i_line_cfg.sel)
      lioenc_pkg::LIOENC_LIN1: stat_d = line_proc[0];
      lioenc_pkg::LIOENC_LIN2: stat_d = line_proc[1];
      lioenc_pkg::LIOENC_LIN3: stat_d = line_proc[2];
      lioenc_pkg::LIOENC_LOUT1: stat_d = out_q[0];
      lioenc_pkg::LIOENC_LOUT2: stat_d = out_q[1];
      default: stat_d = 1'b0;
    endcase
  end

  // Register stage for encoder, filter and outputs
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cand_q <= 2'h0;
      filt_q <= 2'h0;
      fcnt_q <= 2'h0;
      prev_q <= 2'h0;
      rst_prev_q <= 1'b0;
      pos_q <= 20'h00000;
      clr_q <= 32'h00000000;
      dir_q <= 1'b1;
      div_cnt_q <= 8'h00;
      divp_q <= 1'b0;
      divfwd_q <= 1'b1;
      eout_q <= 1'b0;
      out_q <= 2'h0;
      stat_q <= 1'b0;
      ldir_q <= 1'b0;
    end
    else
    begin
      cand_q <= cand_d;
      filt_q <= filt_d;
      fcnt_q <= fcnt_d;
      prev_q <= ab_use;
      rst_prev_q <= rst_lvl;
      pos_q <= pos_d;
      clr_q <= clr_d;
      dir_q <= dir_d;
      div_cnt_q <= div_cnt_d;
      divp_q <= divp_d;
      divfwd_q <= divfwd_d;
      eout_q <= eout_d;
      out_q <= out_d;
      stat_q <= stat_d;
      ldir_q <= ldir_d;
    end
  end

  assign o_line_out = out_q;
  assign o_line_status = stat_q;
  assign o_line_direction = ldir_q;
  assign o_position = pos_q;
  assign o_position_at_clear = clr_q;
  assign o_direction = dir_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks on the encoder and line outputs
  a_sw_clear_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_enc_reset |=> pos_q == 20'h00000)
    else $error("software reset did not clear position");
  a_capture_value: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    rst_any |=> clr_q == {12'h000, $past(pos_q)})
    else $error("position_at_clear missed the count");
  a_pos_in_range: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    pos_q <= `LIOENC_POS_MAX)
    else $error("position above its range");
  a_wrap_up: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (step_fwd && !rst_any && !i_pos_wr && pos_q == `LIOENC_POS_MAX)
    |=> pos_q == 20'h00000 && dir_q)
    else $error("forward step at top did not wrap");
  a_div_one_pass: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ((step_fwd || step_rev) && eff_div == 8'h01) |=> divp_q)
    else $error("divider one dropped a pulse");
  a_hires_step: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (hires && quad_dir(prev_q, ab_raw) == 2'h2 && !rst_any && !i_pos_wr
     && pos_q < `LIOENC_POS_MAX) |=> pos_q == $past(pos_q) + 20'h00001)
    else $error("high resolution transition not counted");
  a_eout_dir: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_enc_cfg.out_mode == lioenc_pkg::LIOENC_EOUT_DIR_UP)
    |=> eout_q == $past(dir_q))
    else $error("direction up output wrong");
  a_out_off: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (src_q[0] == lioenc_pkg::LIOENC_OSRC_OFF) |=> !o_line_out[0])
    else $error("line out one driven while off");

endmodule // lioenc_top

// ### rtl/lioenc_defines.svh
// Purpose: Constants for the line I/O and encoder unit
// Assumes: 100 MHz core clock
// Notes: Offsets-free block, all settings arrive on ports
`ifndef LIOENC_DEFINES_SVH
`define LIOENC_DEFINES_SVH

// Clock period and one microsecond, in ns
`define LIOENC_CLK_PERIOD_NS 10
`define LIOENC_US_NS 1000
// Cycles per microsecond tick
`define LIOENC_CYC_PER_US (`LIOENC_US_NS / `LIOENC_CLK_PERIOD_NS)
// Position counter upper bound
`define LIOENC_POS_MAX 20'hF423F
// Divider range
`define LIOENC_DIV_MIN 8'h01
`define LIOENC_DIV_MAX 8'hC8
// Four-phase input filter: count end value, a phase pair must stand 5 cycles
`define LIOENC_FILT_CYC 2'h3
// Mask time upper bound in microseconds
`define LIOENC_MASK_MAX_US 17'h186A0

`endif

// ### rtl/lioenc_pkg.sv
// Purpose: Types for the line I/O and encoder unit
// Assumes: Constants live in lioenc_defines.svh
// Notes: Enumerations follow the setting choices in order
package lioenc_pkg;

  // Line chosen by the line selector
  typedef enum logic [2:0] {
    LIOENC_LIN1 = 3'h0, LIOENC_LIN2 = 3'h1, LIOENC_LIN3 = 3'h2,
    LIOENC_LOUT1 = 3'h3, LIOENC_LOUT2 = 3'h4
  } lioenc_line_t;

  // Output line sources
  typedef enum logic [2:0] {
    LIOENC_OSRC_OFF = 3'h0, LIOENC_OSRC_ACQ = 3'h1,
    LIOENC_OSRC_FRAME = 3'h2, LIOENC_OSRC_EXPO = 3'h3,
    LIOENC_OSRC_ENC = 3'h4, LIOENC_OSRC_IN1 = 3'h5,
    LIOENC_OSRC_IN2 = 3'h6, LIOENC_OSRC_IN3 = 3'h7
  } lioenc_osrc_t;

  // Encoder phase sources
  typedef enum logic [1:0] {
    LIOENC_ESRC_OFF = 2'h0, LIOENC_ESRC_IN1 = 2'h1,
    LIOENC_ESRC_IN2 = 2'h2, LIOENC_ESRC_IN3 = 2'h3
  } lioenc_esrc_t;

  // Encoder decode modes
  typedef enum logic {
    LIOENC_EMODE_FOUR = 1'h0, LIOENC_EMODE_HIRES = 1'h1
  } lioenc_emode_t;

  // Encoder output modes
  typedef enum logic [2:0] {
    LIOENC_EOUT_OFF = 3'h0, LIOENC_EOUT_POS_UP = 3'h1,
    LIOENC_EOUT_POS_DN = 3'h2, LIOENC_EOUT_DIR_UP = 3'h3,
    LIOENC_EOUT_DIR_DN = 3'h4, LIOENC_EOUT_MOTION = 3'h5
  } lioenc_eout_t;

  // Encoder reset sources
  typedef enum logic [3:0] {
    LIOENC_RSRC_OFF = 4'h0, LIOENC_RSRC_ACQ_END = 4'h1,
    LIOENC_RSRC_FRM_START = 4'h2, LIOENC_RSRC_FRM_END = 4'h3,
    LIOENC_RSRC_EXP_START = 4'h4, LIOENC_RSRC_EXP_END = 4'h5,
    LIOENC_RSRC_IN1 = 4'h6, LIOENC_RSRC_IN2 = 4'h7,
    LIOENC_RSRC_IN3 = 4'h8
  } lioenc_rsrc_t;

  // Encoder reset activations
  typedef enum logic [2:0] {
    LIOENC_RACT_RISE = 3'h0, LIOENC_RACT_FALL = 3'h1,
    LIOENC_RACT_ANY = 3'h2, LIOENC_RACT_HIGH = 3'h3,
    LIOENC_RACT_LOW = 3'h4
  } lioenc_ract_t;

  // Per-line setting write, applied to the selected line
  typedef struct packed {
    lioenc_line_t sel;
    logic inverter;
    lioenc_osrc_t source;
    logic [16:0] rise_mask_time;
    logic [16:0] fall_mask_time;
  } lioenc_line_cfg_t;

  // Encoder settings, held by software as levels
  typedef struct packed {
    lioenc_esrc_t src_a;
    lioenc_esrc_t src_b;
    lioenc_emode_t mode;
    logic [7:0] divider;
    lioenc_eout_t out_mode;
    lioenc_rsrc_t rst_src;
    lioenc_ract_t rst_act;
  } lioenc_enc_cfg_t;

  // Camera timing levels
  typedef struct packed {
    logic acq_active;
    logic frame_active;
    logic exposure_active;
  } lioenc_cam_t;

endpackage

// ### rtl/lioenc_mask.sv
// Purpose: Edge mask for one input line
// Assumes: i_level is already synchronised; i_tick pulses each microsecond
// Notes: Mask time resolves to whole microsecond ticks
`include "lioenc_defines.svh"
module lioenc_mask (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_level,
  input wire logic i_tick,
  input wire logic [16:0] i_rise_mask_time,
  input wire logic [16:0] i_fall_mask_time,
  output logic o_level
);

  logic level_q, level_d; // Accepted level
  logic [16:0] cnt_q, cnt_d; // Remaining mask microseconds

  ////////////////////////////////////////////////////////////////////////
  // Next state: accept a change only when no mask runs
  always_comb
  begin
    level_d = level_q;
    cnt_d = cnt_q;
    if (cnt_q != 17'h00000)
    begin
      // Masking, count down on each tick
      if (i_tick)
        cnt_d = cnt_q - 17'h00001;
    end
    else if (i_level != level_q)
    begin
      // Qualifying edge, start the matching mask time
      level_d = i_level;
      cnt_d = i_level ? i_rise_mask_time : i_fall_mask_time;
    end
  end

  // Register stage
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      level_q <= 1'b0;
      cnt_q <= 17'h00000;
    end
    else
    begin
      level_q <= level_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_level = level_q;

  ////////////////////////////////////////////////////////////////////////
  // A masked rising edge holds the level for the following cycles
  a_mask_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    ($rose(level_q) && $past(i_rise_mask_time) > 17'h00001)
    |-> level_q [*8])
    else $error("line level changed inside rise mask time");

endmodule // lioenc_mask

// ### verification/lioenc_eq_model.sv
// Purpose: Shaft encoder and trigger line equipment model
// Assumes: Lines change on falling clock edges
// Notes: Phase A on line one, phase B on line two, trigger on three
module lioenc_eq_model (
  input wire logic i_clk,
  output logic [2:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////
  // Shaft angle as a quarter-cycle index
  logic [1:0] ph;
  initial
  begin
    ph = 2'h0;
    o_pins = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////
  // Move n steps, each state held for hold cycles (slow or prompt)
  task automatic step(input logic fwd, input int n, input int hold);
    for (int k = 0; k < n; k++)
    begin
      @(negedge i_clk);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      // Forward order AB 00,10,11,01: A leads B
      o_pins[0] = ph[0] ^ ph[1];
      o_pins[1] = ph[1];
      repeat (hold - 1) @(negedge i_clk);
    end
  endtask
  // Trigger line level
  task automatic line3(input logic v);
    @(negedge i_clk);
    o_pins[2] = v;
  endtask
endmodule // lioenc_eq_model

// ### verification/lioenc_top_tb.sv
// Purpose: Self-checking bench for the line I/O and encoder unit
// Assumes: Inputs driven on falling edges, 100 MHz clock
// Notes: Equipment model drives all three line pins
module lioenc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk;
  logic i_arst_n;
  logic [2:0] pins;
  logic i_line_wr;
  lioenc_pkg::lioenc_line_cfg_t i_line_cfg;
  lioenc_pkg::lioenc_enc_cfg_t i_enc_cfg;
  lioenc_pkg::lioenc_cam_t i_cam;
  logic i_enc_reset;
  logic i_pos_wr;
  logic [19:0] i_pos_wdata;
  logic [1:0] o_line_out;
  logic o_line_status;
  logic o_line_direction;
  logic [19:0] o_position;
  logic [31:0] o_position_at_clear;
  logic o_direction;
  int failures;
  int compares;
  int edges;
  logic prev_q;
  ////////////////////////////////////////////////////////////////////
  lioenc_eq_model u_lioenc_eq_model (.i_clk(i_clk), .o_pins(pins));
  lioenc_top u_lioenc_top (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_line_pin(pins),
    .i_line_wr(i_line_wr), .i_line_cfg(i_line_cfg),
    .i_enc_cfg(i_enc_cfg), .i_cam(i_cam), .i_enc_reset(i_enc_reset),
    .i_pos_wr(i_pos_wr), .i_pos_wdata(i_pos_wdata),
    .o_line_out(o_line_out), .o_line_status(o_line_status),
    .o_line_direction(o_line_direction), .o_position(o_position),
    .o_position_at_clear(o_position_at_clear),
    .o_direction(o_direction)
  );
  ////////////////////////////////////////////////////////////////////
  // Clock, 10 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Count rising edges of output line one, sampled where settled
  always @(negedge i_clk)
  begin
    if (o_line_out[0] === 1'b1 && prev_q !== 1'b1)
      edges++;
    prev_q <= o_line_out[0];
  end
  ////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Line setting write to line s
  task automatic set_line(input lioenc_pkg::lioenc_line_t s,
    input logic inv, input lioenc_pkg::lioenc_osrc_t src,
    input logic [16:0] rm);
    @(negedge i_clk);
    i_line_cfg = '{s, inv, src, rm, 17'h0};
    i_line_wr = 1'b1;
    @(negedge i_clk);
    i_line_wr = 1'b0;
  endtask
  // Bounded wait for a position value
  task automatic wait_pos(input logic [19:0] exp);
    int n;
    n = 0;
    while (o_position !== exp && n < 60)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(o_position, exp);
    if (o_position !== exp)
      summarize();
  endtask
  ////////////////////////////////////////////////////////////////////
  // Output sources and inverter
  task automatic t_lines();
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 4; k++)
      begin
        set_line(lioenc_pkg::LIOENC_LOUT1, 1'b0,
          lioenc_pkg::lioenc_osrc_t'(k), 17'h0);
        i_cam = c ? 3'h5 : 3'h2;
        repeat (3) @(negedge i_clk);
        chk(o_line_out[0], k == 0 ? 1'b0 : i_cam[3 - k]);
      end
    chk(o_line_direction, 1'b1);
    set_line(lioenc_pkg::LIOENC_LOUT2, 1'b0,
      lioenc_pkg::LIOENC_OSRC_IN3, 17'h0);
    u_lioenc_eq_model.line3(1'b1);
    repeat (6) @(negedge i_clk);
    chk(o_line_out[1], 1'b1);
    set_line(lioenc_pkg::LIOENC_LIN3, 1'b1,
      lioenc_pkg::LIOENC_OSRC_OFF, 17'h0);
    repeat (6) @(negedge i_clk);
    chk(o_line_out[1], 1'b0);
    chk({o_line_status, o_line_direction}, 2'h0);
    set_line(lioenc_pkg::LIOENC_LIN3, 1'b0,
      lioenc_pkg::LIOENC_OSRC_OFF, 17'h0);
    u_lioenc_eq_model.line3(1'b0);
    i_cam = 3'h0;
    $display("test lines done");
  endtask
  // Counting in both decode modes
  task automatic t_count();
    i_enc_cfg.src_a = lioenc_pkg::LIOENC_ESRC_IN1;
    i_enc_cfg.src_b = lioenc_pkg::LIOENC_ESRC_IN2;
    i_enc_cfg.mode = lioenc_pkg::LIOENC_EMODE_HIRES;
    u_lioenc_eq_model.step(1'b0, 1, 8);
    wait_pos(20'hF423F);
    chk(o_direction, 1'b0);
    u_lioenc_eq_model.step(1'b1, 3, 8);
    wait_pos(20'h00002);
    chk(o_direction, 1'b1);
    i_enc_cfg.mode = lioenc_pkg::LIOENC_EMODE_FOUR;
    u_lioenc_eq_model.step(1'b1, 6, 8);
    wait_pos(20'h00003);
    u_lioenc_eq_model.step(1'b0, 4, 8);
    wait_pos(20'h00002);
    u_lioenc_eq_model.step(1'b1, 4, 2);
    repeat (20) @(negedge i_clk);
    chk(o_position, 20'h00002);
    $display("test count done");
  endtask
  // Writes, software and signal resets
  task automatic pos_write(input logic [19:0] v);
    @(negedge i_clk);
    i_pos_wr = 1'b1;
    i_pos_wdata = v;
    @(negedge i_clk);
    i_pos_wr = 1'b0;
  endtask
  task automatic t_reset();
    i_enc_cfg.mode = lioenc_pkg::LIOENC_EMODE_HIRES;
    pos_write(20'hF423F);
    wait_pos(20'hF423F);
    u_lioenc_eq_model.step(1'b1, 1, 8);
    wait_pos(20'h00000);
    pos_write(20'h12345);
    @(negedge i_clk);
    i_enc_reset = 1'b1;
    @(negedge i_clk);
    i_enc_reset = 1'b0;
    wait_pos(20'h00000);
    chk(o_position_at_clear, 32'h00012345);
    pos_write(20'h00777);
    i_enc_cfg.rst_src = lioenc_pkg::LIOENC_RSRC_FRM_START;
    i_cam.frame_active = 1'b1;
    wait_pos(20'h00000);
    chk(o_position_at_clear, 32'h00000777);
    i_enc_cfg.rst_act = lioenc_pkg::LIOENC_RACT_FALL;
    pos_write(20'h00055);
    repeat (5) @(negedge i_clk);
    chk(o_position, 20'h00055);
    i_cam.frame_active = 1'b0;
    wait_pos(20'h00000);
    i_enc_cfg.rst_act = lioenc_pkg::LIOENC_RACT_LOW;
    pos_write(20'h00099);
    repeat (3) @(negedge i_clk);
    chk(o_position, 20'h00000);
    i_enc_cfg.rst_act = lioenc_pkg::LIOENC_RACT_ANY;
    pos_write(20'h00033);
    i_cam.frame_active = 1'b1;
    wait_pos(20'h00000);
    chk(o_position_at_clear, 32'h00000033);
    i_enc_cfg.rst_src = lioenc_pkg::LIOENC_RSRC_ACQ_END;
    i_enc_cfg.rst_act = lioenc_pkg::LIOENC_RACT_HIGH;
    pos_write(20'h00044);
    repeat (3) @(negedge i_clk);
    chk(o_position, 20'h00000);
    i_enc_cfg.rst_src = lioenc_pkg::LIOENC_RSRC_OFF;
    $display("test reset done");
  endtask
  // Output modes and divider on output line one
  task automatic t_eout();
    lioenc_pkg::lioenc_eout_t m [6];
    int ex [6];
    m = '{lioenc_pkg::LIOENC_EOUT_OFF, lioenc_pkg::LIOENC_EOUT_POS_UP,
      lioenc_pkg::LIOENC_EOUT_POS_DN, lioenc_pkg::LIOENC_EOUT_MOTION,
      lioenc_pkg::LIOENC_EOUT_DIR_UP, lioenc_pkg::LIOENC_EOUT_DIR_DN};
    ex = '{0, 4, 0, 4, 1, 0};
    set_line(lioenc_pkg::LIOENC_LOUT1, 1'b0,
      lioenc_pkg::LIOENC_OSRC_ENC, 17'h0);
    i_enc_cfg.divider = 8'h01;
    for (int k = 0; k < 6; k++)
    begin
      i_enc_cfg.out_mode = m[k];
      edges = 0;
      u_lioenc_eq_model.step(1'b1, 4, 8);
      repeat (20) @(negedge i_clk);
      if (k < 4)
        chk(edges, ex[k]);
      else
        chk(o_line_out[0], ex[k]);
    end
    i_enc_cfg.out_mode = lioenc_pkg::LIOENC_EOUT_POS_UP;
    i_enc_cfg.divider = 8'h03;
    edges = 0;
    u_lioenc_eq_model.step(1'b1, 9, 8);
    repeat (20) @(negedge i_clk);
    chk(edges, 3);
    $display("test eout done");
  endtask
  // Edge mask on line three shown on output line two
  task automatic t_mask();
    for (int k = 0; k < 2; k++)
    begin
      set_line(lioenc_pkg::LIOENC_LIN3, 1'b0,
        lioenc_pkg::LIOENC_OSRC_OFF, k ? 17'h00002 : 17'h0);
      u_lioenc_eq_model.line3(1'b1);
      repeat (20) @(negedge i_clk);
      u_lioenc_eq_model.line3(1'b0);
      repeat (40) @(negedge i_clk);
      chk(o_line_out[1], k);
      repeat (300) @(negedge i_clk);
      chk(o_line_out[1], 1'b0);
    end
    $display("test mask done");
  endtask
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    failures = 0;
    compares = 0;
    edges = 0;
    i_arst_n = 1'b0;
    i_line_wr = 1'b0;
    i_line_cfg = '0;
    i_enc_cfg = '0;
    i_cam = '0;
    i_enc_reset = 1'b0;
    i_pos_wr = 1'b0;
    i_pos_wdata = 20'h00000;
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    i_arst_n = 1'b1;
    chk({o_line_out, o_line_status, o_direction}, 4'h1);
    chk(o_position, 20'h00000);
    chk(o_position_at_clear, 32'h00000000);
    $display("test reset values done");
    t_lines();
    t_count();
    t_reset();
    t_eout();
    t_mask();
    summarize();
  end
endmodule // lioenc_top_tb
